// *** common/pspc_map.vh ***
// Purpose: named constants for the port control pin logic
// Assumes: 100 MHz system clock, eight ports
// Notes:   times are kept in their own unit, cycle counts derive from them
`ifndef PSPC_MAP_VH
`define PSPC_MAP_VH

`define PSPC_NPORT 8
`define PSPC_CLK_MHZ 100
`define PSPC_MS_CYC (`PSPC_CLK_MHZ * 1000)

// deglitch filter: a level must hold for the longest filter time
`define PSPC_FILT_US 5
`define PSPC_FILT_CYC (`PSPC_FILT_US * `PSPC_CLK_MHZ)
`define PSPC_FILT_W 9
`define PSPC_FILT_LAST 9'h1F3

// 3-bit shutdown: quiet gap that closes a pulse train
`define PSPC_GAP_US 40
`define PSPC_GAP_CYC (`PSPC_GAP_US * `PSPC_CLK_MHZ)
`define PSPC_GAP_W 12
`define PSPC_GAP_LAST 12'hF9F
`define PSPC_PULSE_W 4
`define PSPC_PULSE_MAX 4'h8

// port sequencing times
`define PSPC_BACKOFF_MS 400
`define PSPC_PROBE_MS 20
`define PSPC_CLASS_MS 10
`define PSPC_CNT_W 26
// the same times as 26-bit cycle counts at 100 MHz, sized for the counters
`define PSPC_BACKOFF_CYC 26'h2625A00
`define PSPC_PROBE_CYC 26'h01E8480
`define PSPC_CLASS_CYC 26'h00F4240

// internal power-on reset stretch
`define PSPC_POR_CYC 5'h10
`define PSPC_POR_W 5

// synchroniser bus layout (lsb positions)
`define PSPC_SYNC_W 35
`define PSPC_S_FSD 0
`define PSPC_S_RST 1
`define PSPC_S_SUP 2
`define PSPC_S_VH 3
`define PSPC_S_RNG 11
`define PSPC_S_OC 19
`define PSPC_S_ADR 27
`define PSPC_S_SDA 31
`define PSPC_S_AFL 32
`define PSPC_S_ALV 33
`define PSPC_SYNC_RST 35'h0_0000_0002

// fixed upper target address bits above the four straps
`define PSPC_ADDR_HI 3'h2

`endif

// *** dv/pspc_host_model.sv ***
// Purpose: host side of the shutdown pin and the tied i2c data line
// Assumes: shutdown pin changes at falling clock edges, the data line at rising ones
// Notes:   train pulse widths stay above the longest filter time
`timescale 1ns/1ns
`default_nettype none
module pspc_host_model (
   // clock
   input wire logic clk_in,
   // open-drain pull from the device
   input wire logic sda_oe_in,
   // pins toward the device
   output logic fsd_out,
   output logic sda_out
);
   // data pins tied with a pull-up: low only while the device pulls
   assign sda_out = ~sda_oe_in;
   initial fsd_out = 1'b0;
   // one shutdown pulse, active high
   task pulse(input int hi, input int lo);
      fsd_out = 1'b1;
      repeat (hi) @(negedge clk_in);
      fsd_out = 1'b0;
      repeat (lo) @(negedge clk_in);
   endtask
   // pulse train for the 3-bit mode, gaps kept well inside a train
   task train(input int n);
      int i;
      for (i = 0; i < n; i++) pulse(600, 600);
   endtask
endmodule
`default_nettype wire

// *** dv/pspc_props.sv ***
// Purpose: assertions on the pin level port control block
// Assumes: small sequencing parameters, one clock domain
// Notes:   async inputs pass a synchroniser, so input bounds carry slack
`timescale 1ns/1ns
`default_nettype none
`include "pspc_map.vh"
module pspc_props (
   // clock and reset
   input wire logic SYS_CLK_IN,
   input wire logic RST_B_IN,
   // watched inputs
   input wire logic FAST_SHUTDOWN_IN,
   input wire logic SUPPLY_OK_IN,
   input wire logic SHUTDOWN_3BIT_IN,
   input wire logic [7:0] SHUTDOWN_MASK_IN,
   input wire logic I2C_DRIVE_LOW_IN,
   // watched outputs
   input wire logic [7:0] GATE_DRIVE_OUT,
   input wire logic [7:0] DISCHARGE_EN_OUT,
   input wire logic [7:0] PROBE_LOW_OUT,
   input wire logic [7:0] PROBE_HIGH_OUT,
   input wire logic [7:0] VPWR_RES_EN_OUT,
   input wire logic [7:0] IRQ_STATUS_OUT,
   input wire logic IRQ_N_OUT,
   input wire logic IRQ_N_OE_OUT,
   input wire logic I2C_DATA_OUT,
   input wire logic I2C_DATA_OE_OUT,
   input wire logic [6:0] I2C_ADDR_OUT,
   input wire logic IN_RESET_OUT
);
   reg [9:0] fsd_cnt_reg;
   reg [3:0] sup_cnt_reg;
   // saturating run lengths of shutdown high and supply loss
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN || !FAST_SHUTDOWN_IN) fsd_cnt_reg <= 10'h000;
      else if (fsd_cnt_reg != 10'h3FF) fsd_cnt_reg <= fsd_cnt_reg + 10'h001;
      if (!RST_B_IN || SUPPLY_OK_IN) sup_cnt_reg <= 4'h0;
      else if (sup_cnt_reg != 4'hF) sup_cnt_reg <= sup_cnt_reg + 4'h1;
   end
   default clocking cb @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // a settled cycle keeps $past away from reset values
   sequence s_settled; !IN_RESET_OUT && !$past(IN_RESET_OUT); endsequence
   sequence s_held_reset; IN_RESET_OUT && $past(IN_RESET_OUT); endsequence
   property p_irq_pin;
      s_settled |-> !IRQ_N_OUT && IRQ_N_OE_OUT == (|IRQ_STATUS_OUT);
   endproperty
   property p_fsd_kill;
      (fsd_cnt_reg >= 10'h1FE && !SHUTDOWN_3BIT_IN)
         |-> (GATE_DRIVE_OUT & SHUTDOWN_MASK_IN) == 8'h00;
   endproperty
   property p_supply; sup_cnt_reg == 4'hF |-> GATE_DRIVE_OUT == 8'h00;
   endproperty
   property p_por; $rose(RST_B_IN) |-> IN_RESET_OUT[*8]; endproperty
   property p_reset_outs;
      s_held_reset |-> GATE_DRIVE_OUT == 8'h00 && DISCHARGE_EN_OUT == 8'h00
         && VPWR_RES_EN_OUT == 8'hFF && !IRQ_N_OE_OUT;
   endproperty
   property p_vpwr_res;
      (VPWR_RES_EN_OUT & (PROBE_LOW_OUT | PROBE_HIGH_OUT | GATE_DRIVE_OUT))
         == 8'h00;
   endproperty
   property p_probe_order;
      $rose(PROBE_HIGH_OUT[0]) |-> $past(PROBE_LOW_OUT[0]) && !PROBE_LOW_OUT[0];
   endproperty
   property p_i2c;
      s_settled |-> I2C_DATA_OE_OUT == $past(I2C_DRIVE_LOW_IN) && !I2C_DATA_OUT;
   endproperty
   property p_addr;
      s_settled |-> I2C_ADDR_OUT[6:4] == `PSPC_ADDR_HI && $stable(I2C_ADDR_OUT);
   endproperty
   a_irq_pin: assert property (p_irq_pin)
      else $error("irq pin does not follow status");
   a_fsd_kill: assert property (p_fsd_kill)
      else $error("masked gate on after held shutdown");
   a_supply: assert property (p_supply)
      else $error("gate on during supply loss");
   a_por: assert property (p_por)
      else $error("reset stretch too short");
   a_reset_outs: assert property (p_reset_outs)
      else $error("port outputs active in reset");
   a_vpwr_res: assert property (p_vpwr_res)
      else $error("supply resistor on while probing or powered");
   a_probe_order: assert property (p_probe_order)
      else $error("second probe level without first");
   a_i2c: assert property (p_i2c)
      else $error("data pull-down not one cycle after request");
   a_addr: assert property (p_addr)
      else $error("target address upper bits or capture wrong");
endmodule
bind pspc_top pspc_props u_props (.SYS_CLK_IN(SYS_CLK_IN),
   .RST_B_IN(RST_B_IN), .FAST_SHUTDOWN_IN(FAST_SHUTDOWN_IN),
   .SUPPLY_OK_IN(SUPPLY_OK_IN), .SHUTDOWN_3BIT_IN(SHUTDOWN_3BIT_IN),
   .SHUTDOWN_MASK_IN(SHUTDOWN_MASK_IN), .I2C_DRIVE_LOW_IN(I2C_DRIVE_LOW_IN),
   .GATE_DRIVE_OUT(GATE_DRIVE_OUT), .DISCHARGE_EN_OUT(DISCHARGE_EN_OUT),
   .PROBE_LOW_OUT(PROBE_LOW_OUT), .PROBE_HIGH_OUT(PROBE_HIGH_OUT),
   .VPWR_RES_EN_OUT(VPWR_RES_EN_OUT), .IRQ_STATUS_OUT(IRQ_STATUS_OUT),
   .IRQ_N_OUT(IRQ_N_OUT), .IRQ_N_OE_OUT(IRQ_N_OE_OUT),
   .I2C_DATA_OUT(I2C_DATA_OUT), .I2C_DATA_OE_OUT(I2C_DATA_OE_OUT),
   .I2C_ADDR_OUT(I2C_ADDR_OUT), .IN_RESET_OUT(IN_RESET_OUT));
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: self-checking bench for the port control pin logic
// Assumes: small sequencing parameters 40, 20 and 10 cycles
// Notes:   detection is disabled during pulse trains so kills stay visible
`timescale 1ns/1ns
`default_nettype none
`include "pspc_map.vh"
module tb;
   logic clk = 1'b0, rst_b = 1'b0, rpin_b = 1'b1, sup_ok = 1'b1;
   logic mode3 = 1'b0, drv_low = 1'b0, afloat = 1'b1;
   logic [1:0] alvl = 2'h0;
   logic [3:0] straps = 4'hF;
   logic [7:0] hv = 8'h00, load = 8'hFF, oc = 8'h00, mask = 8'h01;
   logic [7:0] det = 8'h00, pwr = 8'h00, prst = 8'h00, clr = 8'h00, bit_k;
   logic [23:0] prio = 24'h000000;
   wire fsd, sda, irq_n, irq_oe, sda_o, sda_oe, sda_rx, auto_en, in_rst;
   wire [7:0] gate, dis, plo, phi, vres, cls, irq;
   wire [6:0] addr;
   wire [1:0] auto_lvl;
   integer seed, fails = 0, checks = 0, n, i;
   // 100 MHz system clock
   always #5 clk = ~clk;
   pspc_host_model host (.clk_in(clk), .sda_oe_in(sda_oe), .fsd_out(fsd),
      .sda_out(sda));
   pspc_top #(.BACKOFF_CYC(26'd40), .PROBE_CYC(26'd20), .CLASS_CYC(26'd10))
   DUT (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .FAST_SHUTDOWN_IN(fsd),
      .RESET_PIN_B_IN(rpin_b), .SUPPLY_OK_IN(sup_ok), .PORT_HIGH_V_IN(hv),
      .LOAD_IN_RANGE_IN(load), .OC_TIMEOUT_IN(oc), .ADDR_STRAP_IN(straps),
      .I2C_DATA_IN(sda), .AUTO_FLOAT_IN(afloat), .AUTO_LEVEL_IN(alvl),
      .SHUTDOWN_3BIT_IN(mode3), .SHUTDOWN_MASK_IN(mask), .PORT_PRIO_IN(prio),
      .DETECT_EN_IN(det), .POWER_EN_IN(pwr), .PORT_RESET_IN(prst),
      .IRQ_CLEAR_IN(clr), .I2C_DRIVE_LOW_IN(drv_low), .GATE_DRIVE_OUT(gate),
      .DISCHARGE_EN_OUT(dis), .PROBE_LOW_OUT(plo), .PROBE_HIGH_OUT(phi),
      .VPWR_RES_EN_OUT(vres), .CLASS_ACTIVE_OUT(cls), .IRQ_STATUS_OUT(irq),
      .IRQ_N_OUT(irq_n), .IRQ_N_OE_OUT(irq_oe), .I2C_DATA_OUT(sda_o),
      .I2C_DATA_OE_OUT(sda_oe), .I2C_DATA_RX_OUT(sda_rx),
      .I2C_ADDR_OUT(addr), .AUTO_EN_OUT(auto_en), .AUTO_LEVEL_OUT(auto_lvl),
      .IN_RESET_OUT(in_rst));
   // verdict and end of run
   task report_and_stop;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // compare one seen value with its expectation
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function logic [7:0] sel(input int w);
      sel = (w == 0) ? {7'h00, in_rst} : (w == 1) ? gate : cls;
   endfunction
   // bounded wait for reset flag, gates or classification to match
   task wait_for(input int w, input logic [7:0] e);
      int c;
      for (c = 0; c < 3000 && sel(w) !== e; c++) @(negedge clk);
      if (c == 3000) begin
         fails++;
         $display("ERROR %0t: wait %0d timed out", $time, w);
         report_and_stop();
      end
   endtask
   // ports with priority at or above pulses minus one go off
   function logic [7:0] kill3(input logic [23:0] pr, input int p);
      for (int k = 0; k < 8; k++) kill3[k] = (pr[3*k+:3] >= p - 1);
   endfunction
   // a kill just happened: check gates and flags, then bring ports back
   task killed(input logic [7:0] off);
      repeat (12) @(negedge clk);
      chk(gate, ~off);
      chk(irq, off);
      chk({7'h00, irq_oe}, {7'h00, |off});
   endtask
   task restore(input logic [7:0] off);
      clr = off;
      @(negedge clk);
      clr = 8'h00;
      det = 8'hFF;
      wait_for(1, 8'hFF);
   endtask
   // main sequence
   initial begin
      seed = 32'h9c6ae4ff;
      straps = $random(seed);
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      wait_for(0, 8'h00);
      chk({1'b0, addr}, {1'b0, `PSPC_ADDR_HI, straps});
      chk({7'h00, auto_en}, 8'h00);
      det = 8'hFF;
      pwr = 8'hFF;
      load = 8'hFD;
      wait_for(2, 8'hFD);
      wait_for(1, 8'hFD);
      load = 8'hFF;
      wait_for(1, 8'hFF);
      // port reset command with a charged port: backoff follows
      bit_k = 8'h01 << ($unsigned($random(seed)) % 8);
      hv = bit_k;
      // let the high port voltage pass the synchroniser first
      repeat (5) @(negedge clk);
      prst = bit_k;
      @(negedge clk);
      prst = 8'h00;
      repeat (7) @(negedge clk);
      chk(dis, bit_k);
      hv = 8'h00;
      killed(bit_k);
      restore(bit_k);
      // short shutdown pulse is filtered, long one kills masked ports
      mask = $random(seed) | 8'h01;
      host.pulse(300, 20);
      chk(gate, 8'hFF);
      chk(irq, 8'h00);
      host.pulse(600, 0);
      chk(gate, ~mask);
      chk(irq, mask);
      restore(mask);
      // 3-bit trains, the first one over-long so the count saturates
      mode3 = 1'b1;
      prio = $random(seed);
      for (i = 0; i < 2; i++) begin
         n = (i == 0) ? 9 : 1 + $unsigned($random(seed)) % 7;
         det = 8'h00;
         host.train(n);
         repeat (4100) @(negedge clk);
         chk(gate, ~kill3(prio, (n > 8) ? 8 : n));
         restore(kill3(prio, (n > 8) ? 8 : n));
      end
      mode3 = 1'b0;
      // overcurrent on one port, then supply loss on all
      oc = bit_k;
      killed(bit_k);
      oc = 8'h00;
      restore(bit_k);
      sup_ok = 1'b0;
      killed(8'hFF);
      sup_ok = 1'b1;
      restore(8'hFF);
      // straps are taken after a reset: set the auto pin, then reset
      afloat = 1'b0;
      alvl = $random(seed);
      // filtered reset pin clears ports and status
      rpin_b = 1'b0;
      repeat (520) @(negedge clk);
      chk({7'h00, in_rst}, 8'h01);
      chk(gate, 8'h00);
      chk(irq, 8'h00);
      rpin_b = 1'b1;
      wait_for(0, 8'h00);
      chk({7'h00, auto_en}, 8'h01);
      chk({6'h00, auto_lvl}, {6'h00, alvl});
      // data pull-down and receive path over the tied line
      for (i = 0; i < 4; i++) begin
         drv_low = $random(seed);
         repeat (8) @(negedge clk);
         chk({7'h00, sda_oe}, {7'h00, drv_low});
         chk({7'h00, sda_rx}, {7'h00, ~drv_low});
      end
      report_and_stop();
   end
endmodule
`default_nettype wire

// *** rtl/pspc_top.v ***
// Purpose: pin level control of an eight port power sourcing controller
// Assumes: pins arrive asynchronous; host config bits are on SYS_CLK_IN
// Notes:   analog probing, classification and current limit sit outside;
//          this block sequences them and owns the gate enables
`timescale 1ns/1ns
`default_nettype none
`include "pspc_map.vh"

module pspc_top #(
   parameter [25:0] BACKOFF_CYC = `PSPC_BACKOFF_CYC,
   parameter [25:0] PROBE_CYC = `PSPC_PROBE_CYC,
   parameter [25:0] CLASS_CYC = `PSPC_CLASS_CYC
) (
   // clock and reset
   input wire SYS_CLK_IN,
   input wire RST_B_IN,
   // asynchronous pins and analog comparators
   input wire FAST_SHUTDOWN_IN,
   input wire RESET_PIN_B_IN,
   input wire SUPPLY_OK_IN,
   input wire [7:0] PORT_HIGH_V_IN,
   input wire [7:0] LOAD_IN_RANGE_IN,
   input wire [7:0] OC_TIMEOUT_IN,
   input wire [3:0] ADDR_STRAP_IN,
   input wire I2C_DATA_IN,
   input wire AUTO_FLOAT_IN,
   input wire [1:0] AUTO_LEVEL_IN,
   // host side controls, same clock
   input wire SHUTDOWN_3BIT_IN,
   input wire [7:0] SHUTDOWN_MASK_IN,
   input wire [23:0] PORT_PRIO_IN,
   input wire [7:0] DETECT_EN_IN,
   input wire [7:0] POWER_EN_IN,
   input wire [7:0] PORT_RESET_IN,
   input wire [7:0] IRQ_CLEAR_IN,
   input wire I2C_DRIVE_LOW_IN,
   // port drive
   output reg [7:0] GATE_DRIVE_OUT,
   output reg [7:0] DISCHARGE_EN_OUT,
   output reg [7:0] PROBE_LOW_OUT,
   output reg [7:0] PROBE_HIGH_OUT,
   output reg [7:0] VPWR_RES_EN_OUT,
   output reg [7:0] CLASS_ACTIVE_OUT,
   // interrupt
   output reg [7:0] IRQ_STATUS_OUT,
   output reg IRQ_N_OUT,
   output reg IRQ_N_OE_OUT,
   // i2c data pins and address
   output reg I2C_DATA_OUT,
   output reg I2C_DATA_OE_OUT,
   output reg I2C_DATA_RX_OUT,
   output reg [6:0] I2C_ADDR_OUT,
   // straps and reset state
   output reg AUTO_EN_OUT,
   output reg [1:0] AUTO_LEVEL_OUT,
   output reg IN_RESET_OUT
);

   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_BACKOFF = 3'h1;
   localparam [2:0] ST_PROBE_LO = 3'h2;
   localparam [2:0] ST_PROBE_HI = 3'h3;
   localparam [2:0] ST_CLASS = 3'h4;
   localparam [2:0] ST_READY = 3'h5;
   localparam [2:0] ST_ON = 3'h6;

   // accept a bit once the second and third stages agree
   function [`PSPC_SYNC_W-1:0] agree;
      input [`PSPC_SYNC_W-1:0] s2;
      input [`PSPC_SYNC_W-1:0] s3;
      input [`PSPC_SYNC_W-1:0] acc;
      begin
         agree = (s2 & s3) | (acc & (s2 | s3));
      end
   endfunction

   // ports whose priority number is at or above the received level
   function [7:0] prio_kill;
      input [23:0] prio;
      input [2:0] code;
      integer k;
      begin
         prio_kill = 8'h00;
         for (k = 0; k < `PSPC_NPORT; k = k + 1) begin
            prio_kill[k] = (prio[3*k +: 3] >= code);
         end
      end
   endfunction

   wire [`PSPC_SYNC_W-1:0] pins;
   reg [`PSPC_SYNC_W-1:0] s1_reg;
   reg [`PSPC_SYNC_W-1:0] s2_reg;
   reg [`PSPC_SYNC_W-1:0] s3_reg;
   reg [`PSPC_SYNC_W-1:0] acc_reg;
   reg [`PSPC_POR_W-1:0] por_cnt_reg;
   reg [`PSPC_FILT_W-1:0] fsd_cnt_reg;
   reg fsd_lvl_reg;
   reg fsd_prev_reg;
   reg [`PSPC_FILT_W-1:0] rst_cnt_reg;
   reg rst_lvl_reg;
   reg [`PSPC_PULSE_W-1:0] pulse_cnt_reg;
   reg [`PSPC_GAP_W-1:0] gap_cnt_reg;
   reg [7:0] code_kill_reg;
   reg strap_done_reg;
   reg [7:0] irq_reg;
   reg [2:0] st_reg [0:7];
   reg [25:0] cnt_reg [0:7];
   reg [7:0] lo_ok_reg;
   wire soft_rst;
   wire [7:0] fsd_kill;
   wire [7:0] kill;
   wire [7:0] irq_set;
   wire sup_ok;
   integer i;
   integer j;

   assign pins = {AUTO_LEVEL_IN, AUTO_FLOAT_IN, I2C_DATA_IN, ADDR_STRAP_IN,
                  OC_TIMEOUT_IN, LOAD_IN_RANGE_IN, PORT_HIGH_V_IN,
                  SUPPLY_OK_IN, RESET_PIN_B_IN, FAST_SHUTDOWN_IN};

   // three stage synchroniser; stage one feeds stage two only
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         s1_reg <= `PSPC_SYNC_RST;
         s2_reg <= `PSPC_SYNC_RST;
         s3_reg <= `PSPC_SYNC_RST;
         acc_reg <= `PSPC_SYNC_RST;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         acc_reg <= agree(s2_reg, s3_reg, acc_reg);
      end
   end

   // internal power-on reset stretch, blind to the reset pin
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         por_cnt_reg <= {`PSPC_POR_W{1'b0}};
      end else if (por_cnt_reg != `PSPC_POR_CYC) begin
         por_cnt_reg <= por_cnt_reg + 1'b1;
      end
   end

   // fast shutdown filter: any pulse shorter than the window is lost
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         fsd_cnt_reg <= {`PSPC_FILT_W{1'b0}};
         fsd_lvl_reg <= 1'b0;
      end else if (acc_reg[`PSPC_S_FSD] != fsd_lvl_reg) begin
         if (fsd_cnt_reg == `PSPC_FILT_LAST) begin
            fsd_lvl_reg <= acc_reg[`PSPC_S_FSD];
            fsd_cnt_reg <= {`PSPC_FILT_W{1'b0}};
         end else begin
            fsd_cnt_reg <= fsd_cnt_reg + 1'b1;
         end
      end else begin
         fsd_cnt_reg <= {`PSPC_FILT_W{1'b0}};
      end
   end

   // reset pin filter, idles released (high)
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         rst_cnt_reg <= {`PSPC_FILT_W{1'b0}};
         rst_lvl_reg <= 1'b1;
      end else if (acc_reg[`PSPC_S_RST] != rst_lvl_reg) begin
         if (rst_cnt_reg == `PSPC_FILT_LAST) begin
            rst_lvl_reg <= acc_reg[`PSPC_S_RST];
            rst_cnt_reg <= {`PSPC_FILT_W{1'b0}};
         end else begin
            rst_cnt_reg <= rst_cnt_reg + 1'b1;
         end
      end else begin
         rst_cnt_reg <= {`PSPC_FILT_W{1'b0}};
      end
   end

   assign soft_rst = (por_cnt_reg != `PSPC_POR_CYC) | ~rst_lvl_reg;
   assign sup_ok = acc_reg[`PSPC_S_SUP];

   // 3-bit shutdown: count filtered pulses, act after a quiet gap
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN || soft_rst) begin
         fsd_prev_reg <= 1'b0;
         pulse_cnt_reg <= {`PSPC_PULSE_W{1'b0}};
         gap_cnt_reg <= {`PSPC_GAP_W{1'b0}};
         code_kill_reg <= 8'h00;
      end else begin
         fsd_prev_reg <= fsd_lvl_reg;
         code_kill_reg <= 8'h00;
         if (fsd_lvl_reg && !fsd_prev_reg) begin
            gap_cnt_reg <= {`PSPC_GAP_W{1'b0}};
            if (pulse_cnt_reg != `PSPC_PULSE_MAX) begin
               pulse_cnt_reg <= pulse_cnt_reg + 1'b1;
            end
         end else if (pulse_cnt_reg != {`PSPC_PULSE_W{1'b0}} &&
                      !fsd_lvl_reg) begin
            if (gap_cnt_reg == `PSPC_GAP_LAST) begin
               // one pulse selects level 0, eight pulses level 7
               code_kill_reg <= prio_kill(PORT_PRIO_IN,
                  pulse_cnt_reg[2:0] - 3'h1);
               pulse_cnt_reg <= {`PSPC_PULSE_W{1'b0}};
               gap_cnt_reg <= {`PSPC_GAP_W{1'b0}};
            end else begin
               gap_cnt_reg <= gap_cnt_reg + 1'b1;
            end
         end
      end
   end

   // single pulse mode is a held level on masked ports
   assign fsd_kill = SHUTDOWN_3BIT_IN ? code_kill_reg :
                     (fsd_lvl_reg ? SHUTDOWN_MASK_IN : 8'h00);
   // shutdown shares the port reset command's path
   // overcurrent comes from a pin, so only its synchronised copy is used
   assign kill = PORT_RESET_IN | fsd_kill | acc_reg[`PSPC_S_OC +: 8] |
                 {8{~sup_ok}};
   assign irq_set = {st_reg[7] == ST_ON, st_reg[6] == ST_ON,
                     st_reg[5] == ST_ON, st_reg[4] == ST_ON,
                     st_reg[3] == ST_ON, st_reg[2] == ST_ON,
                     st_reg[1] == ST_ON, st_reg[0] == ST_ON} & kill;

   // straps are caught once after each reset, never while held
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN || soft_rst) begin
         strap_done_reg <= 1'b0;
         AUTO_EN_OUT <= 1'b0;
         AUTO_LEVEL_OUT <= 2'h0;
         I2C_ADDR_OUT <= 7'h00;
      end else if (!strap_done_reg) begin
         strap_done_reg <= 1'b1;
         AUTO_EN_OUT <= ~acc_reg[`PSPC_S_AFL];
         AUTO_LEVEL_OUT <= acc_reg[`PSPC_S_ALV +: 2];
         I2C_ADDR_OUT <= {`PSPC_ADDR_HI, acc_reg[`PSPC_S_ADR +: 4]};
      end
   end

   // interrupt register: a new event beats a same-cycle clear
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN || soft_rst) begin
         irq_reg <= 8'h00;
         IRQ_STATUS_OUT <= 8'h00;
         IRQ_N_OUT <= 1'b0;
         IRQ_N_OE_OUT <= 1'b0;
      end else begin
         irq_reg <= (irq_reg & ~IRQ_CLEAR_IN) | irq_set;
         IRQ_STATUS_OUT <= (irq_reg & ~IRQ_CLEAR_IN) | irq_set;
         IRQ_N_OUT <= 1'b0;
         IRQ_N_OE_OUT <= |((irq_reg & ~IRQ_CLEAR_IN) | irq_set);
      end
   end

   // i2c: receive on its own pin, drive only by pulling low
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         I2C_DATA_OUT <= 1'b0;
         I2C_DATA_OE_OUT <= 1'b0;
         I2C_DATA_RX_OUT <= 1'b1;
      end else begin
         I2C_DATA_OUT <= 1'b0;
         I2C_DATA_OE_OUT <= I2C_DRIVE_LOW_IN;
         I2C_DATA_RX_OUT <= acc_reg[`PSPC_S_SDA];
      end
   end

   // per-port sequencers run side by side, no shared arbiter
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN || soft_rst) begin
         for (i = 0; i < `PSPC_NPORT; i = i + 1) begin
            st_reg[i] <= ST_IDLE;
            cnt_reg[i] <= 26'h0;
         end
         lo_ok_reg <= 8'h00;
      end else begin
         for (i = 0; i < `PSPC_NPORT; i = i + 1) begin
            cnt_reg[i] <= cnt_reg[i] + 26'h1;
            if (kill[i]) begin
               st_reg[i] <= ST_IDLE;
               cnt_reg[i] <= 26'h0;
            end else begin
               case (st_reg[i])
                  ST_IDLE: begin
                     cnt_reg[i] <= 26'h0;
                     if (DETECT_EN_IN[i] || AUTO_EN_OUT) begin
                        if (acc_reg[`PSPC_S_VH + i]) begin
                           st_reg[i] <= ST_BACKOFF;
                        end else begin
                           st_reg[i] <= ST_PROBE_LO;
                        end
                     end
                  end
                  ST_BACKOFF: begin
                     if (cnt_reg[i] == BACKOFF_CYC - 26'h1) begin
                        st_reg[i] <= ST_PROBE_LO;
                        cnt_reg[i] <= 26'h0;
                     end
                  end
                  ST_PROBE_LO: begin
                     if (cnt_reg[i] == PROBE_CYC - 26'h1) begin
                        lo_ok_reg[i] <= acc_reg[`PSPC_S_RNG + i];
                        st_reg[i] <= ST_PROBE_HI;
                        cnt_reg[i] <= 26'h0;
                     end
                  end
                  ST_PROBE_HI: begin
                     if (cnt_reg[i] == PROBE_CYC - 26'h1) begin
                        cnt_reg[i] <= 26'h0;
                        if (lo_ok_reg[i] && acc_reg[`PSPC_S_RNG + i]) begin
                           st_reg[i] <= ST_CLASS;
                        end else begin
                           st_reg[i] <= ST_IDLE;
                        end
                     end
                  end
                  ST_CLASS: begin
                     if (cnt_reg[i] == CLASS_CYC - 26'h1) begin
                        st_reg[i] <= ST_READY;
                     end
                  end
                  ST_READY: begin
                     if (POWER_EN_IN[i] || AUTO_EN_OUT) begin
                        st_reg[i] <= ST_ON;
                     end else if (!DETECT_EN_IN[i] && !AUTO_EN_OUT) begin
                        st_reg[i] <= ST_IDLE;
                     end
                  end
                  ST_ON: begin
                     if (!POWER_EN_IN[i] && !AUTO_EN_OUT) begin
                        st_reg[i] <= ST_IDLE;
                     end
                  end
                  default: begin
                     st_reg[i] <= ST_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // port drive flops; gate also drops on a kill seen this cycle
   always @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN || soft_rst) begin
         GATE_DRIVE_OUT <= 8'h00;
         DISCHARGE_EN_OUT <= 8'h00;
         PROBE_LOW_OUT <= 8'h00;
         PROBE_HIGH_OUT <= 8'h00;
         VPWR_RES_EN_OUT <= 8'hFF;
         CLASS_ACTIVE_OUT <= 8'h00;
         IN_RESET_OUT <= 1'b1;
      end else begin
         IN_RESET_OUT <= 1'b0;
         for (j = 0; j < `PSPC_NPORT; j = j + 1) begin
            GATE_DRIVE_OUT[j] <= (st_reg[j] == ST_ON) & ~kill[j];
            DISCHARGE_EN_OUT[j] <= (st_reg[j] == ST_BACKOFF);
            PROBE_LOW_OUT[j] <= (st_reg[j] == ST_PROBE_LO);
            PROBE_HIGH_OUT[j] <= (st_reg[j] == ST_PROBE_HI);
            VPWR_RES_EN_OUT[j] <= (st_reg[j] != ST_PROBE_LO) &&
                                  (st_reg[j] != ST_PROBE_HI) &&
                                  (st_reg[j] != ST_ON);
            CLASS_ACTIVE_OUT[j] <= (st_reg[j] == ST_CLASS);
         end
      end
   end

endmodule
`default_nettype wire
